// *** hdl/addr_bus_ctrl_gpio_ports.sv ***
// narrow (4-bit) upper-address port and wide (7-bit) bus-control port
// assumes axi4-lite master on aclk, bus controller strobes on aclk, pins asynchronous
//
// Overview of operation
// - modes 1-4: narrow pins are address outputs
// - mode 5: direction picks address out or input
// - modes 6-7: narrow direction bit selects per pin
// - modes 5-7: narrow direction reads all ones
// - narrow direction resets 0xf0, kept in soft standby
// - output pins hold state in software standby
// - narrow data read: stored if output, else pin
// - narrow data upper nibble is plain storage
// - narrow data resets 0xf0, kept in soft standby
// - pull-up on when enabled and input, modes 5-7
// - pull-up control resets 0xf0, all pull-ups off
// - modes 1-5: pins 6-3 drive bus strobes
// - expanded: pin 2 grant out when release enabled
// - expanded: pin 1 request in when release enabled
// - expanded: pin 0 wait input per wait settings
// - modes 6-7: wide direction bit selects per pin
// - wide direction write-only, reads ones, resets 0x80
// - wide data read mixes stored/pin, bit 7 one
// - wide data resets 0x80, kept in soft standby
// - dram area 3 reuses write/read strobe pins
`timescale 1ns/1ps
module addr_bus_ctrl_gpio_ports
	import port_pkg::*;
(
	input wire logic aclk, // system clock, 25 MHz
	input wire logic aresetn, // synchronous reset, low active
	input wire logic [ADDR_W-1:0] s_axi_awaddr, // write address
	input wire logic s_axi_awvalid, // write address valid
	output logic s_axi_awready, // write address ready
	input wire logic [31:0] s_axi_wdata, // write data
	input wire logic [3:0] s_axi_wstrb, // write byte enables
	input wire logic s_axi_wvalid, // write data valid
	output logic s_axi_wready, // write data ready
	output logic [1:0] s_axi_bresp, // write response
	output logic s_axi_bvalid, // write response valid
	input wire logic s_axi_bready, // write response ready
	input wire logic [ADDR_W-1:0] s_axi_araddr, // read address
	input wire logic s_axi_arvalid, // read address valid
	output logic s_axi_arready, // read address ready
	output logic [31:0] s_axi_rdata, // read data
	output logic [1:0] s_axi_rresp, // read response
	output logic s_axi_rvalid, // read data valid
	input wire logic s_axi_rready, // read data ready
	input wire logic [2:0] mode_pins, // operating mode straps
	input wire logic hw_standby, // hardware standby, high active
	input wire logic sw_standby, // software standby, high active
	input wire logic [3:0] upper_addr, // address bits 19..16
	input wire logic low_byte_write_strobe_n, // bus controller strobe
	input wire logic high_byte_write_strobe_n, // bus controller strobe
	input wire logic read_strobe_n, // bus controller strobe
	input wire logic addr_strobe_n, // bus controller strobe
	input wire logic bus_grant_ack_n, // bus-release acknowledge
	input wire logic bus_release_enable, // release enable bit of bus_release_ctrl
	input wire logic [7:0] wait_state_enables, // per-area wait enables
	input wire logic wait_mode_sel_high, // wait_ctrl mode select bit
	input wire logic dram_area3, // dram occupies area 3
	input wire logic dram_alt_assign, // second strobe assignment
	input wire logic dram_lower_write_n, // dram strobe, first assignment
	input wire logic dram_upper_write_n, // dram strobe, first assignment
	input wire logic dram_column_strobe_n, // dram strobe, first assignment
	input wire logic dram_lower_column_strobe_n, // dram strobe, second assignment
	input wire logic dram_upper_column_strobe_n, // dram strobe, second assignment
	input wire logic dram_write_enable_n, // dram strobe, second assignment
	input wire logic [NARROW_W-1:0] narrow_pin_in, // narrow pin levels
	output logic [NARROW_W-1:0] narrow_pin_out, // narrow pin drive value
	output logic [NARROW_W-1:0] narrow_pin_oe, // narrow pin drive enable
	output logic [NARROW_W-1:0] narrow_pullup_on, // narrow pull-up enable
	input wire logic [WIDE_W-1:0] wide_pin_in, // wide pin levels
	output logic [WIDE_W-1:0] wide_pin_out, // wide pin drive value
	output logic [WIDE_W-1:0] wide_pin_oe, // wide pin drive enable
	output logic bus_request_in_n, // filtered bus request to controller
	output logic wait_in_n // filtered wait to controller
);
	logic [2:0] mode_q;
	logic [7:0] narrow_dir_q;
	logic [7:0] wide_dir_q;
	logic [7:0] narrow_data_q;
	logic [7:0] wide_data_q;
	logic [7:0] narrow_pullup_q;
	logic awready_q;
	logic wready_q;
	logic bvalid_q;
	logic [1:0] bresp_q;
	logic arready_q;
	logic rvalid_q;
	logic [1:0] rresp_q;
	logic [31:0] rdata_q;
	logic [NARROW_W-1:0] n_out_q;
	logic [NARROW_W-1:0] n_oe_q;
	logic [NARROW_W-1:0] n_pu_q;
	logic [WIDE_W-1:0] w_out_q;
	logic [WIDE_W-1:0] w_oe_q;
	logic bus_request_in_q;
	logic wait_q;
	logic romless;
	logic expanded;
	logic single;
	logic [NARROW_W-1:0] n_dir_eff;
	logic [NARROW_W-1:0] n_sync;
	logic [WIDE_W-1:0] w_sync;
	logic wr_fire;
	logic rd_fire;
	logic [15:0] wr_idx;
	logic [15:0] rd_idx;
	logic wr_hit;
	logic [7:0] wbyte;
	logic store_reset;
	logic wait_pin_fn;
	logic [7:0] rd_byte;
	logic rd_hit;
	logic [NARROW_W-1:0] n_out_d;
	logic [NARROW_W-1:0] n_oe_d;
	logic [NARROW_W-1:0] n_pu_d;
	logic [WIDE_W-1:0] w_out_d;
	logic [WIDE_W-1:0] w_oe_d;

	pin_sync_if #(.W(NARROW_W)) n_if ();
	pin_sync_if #(.W(WIDE_W)) w_if ();
	assign n_if.raw = narrow_pin_in;
	assign w_if.raw = wide_pin_in;
	assign n_sync = n_if.stable;
	assign w_sync = w_if.stable;

	pin_sync #(.W(NARROW_W)) u_narrow_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.s(n_if)
	);

	pin_sync #(.W(WIDE_W)) u_wide_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.s(w_if)
	);

	// straps follow the pins while reset is low and freeze at release
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			mode_q <= mode_pins;
	end

	assign romless = (mode_q <= MODE_ROMLESS_LAST);
	assign single = (mode_q >= MODE_SINGLE_FIRST);
	assign expanded = !single;
	// address-only modes hide the stored direction behind all ones
	assign n_dir_eff = romless ? '1 : narrow_dir_q[NARROW_W-1:0];

	// register write side
	assign wr_fire = awready_q && s_axi_awvalid && wready_q && s_axi_wvalid;
	// a misaligned write maps to an unused index, so it lands nowhere
	assign wr_idx = (s_axi_awaddr[1:0] == 2'h0) ? s_axi_awaddr[17:2] : '0;
	assign wbyte = s_axi_wdata[7:0];
	assign wr_hit = (s_axi_awaddr[1:0] == 2'h0) &&
		(wr_idx == IDX_NARROW_DIR || wr_idx == IDX_WIDE_DIR ||
		wr_idx == IDX_NARROW_DATA || wr_idx == IDX_WIDE_DATA ||
		wr_idx == IDX_NARROW_PULLUP);
	assign store_reset = !aresetn || hw_standby;

	// address and data are taken together, one write in flight
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			awready_q <= 1'b0;
			wready_q <= 1'b0;
		end
		else
		begin
			awready_q <= !awready_q && s_axi_awvalid && s_axi_wvalid && !bvalid_q;
			wready_q <= !wready_q && s_axi_awvalid && s_axi_wvalid && !bvalid_q;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
		end
		else if (wr_fire)
		begin
			bvalid_q <= 1'b1;
			bresp_q <= wr_hit ? RESP_OKAY : RESP_DECERR;
		end
		else if (s_axi_bready)
			bvalid_q <= 1'b0;
	end

	// soft standby needs no gating: contents simply stay
	always_ff @(posedge aclk)
	begin
		if (store_reset)
			narrow_dir_q <= RST_NARROW_DIR;
		else if (wr_fire && wr_idx == IDX_NARROW_DIR && s_axi_wstrb[0] && !romless)
			narrow_dir_q <= wbyte;
	end

	always_ff @(posedge aclk)
	begin
		if (store_reset)
			wide_dir_q <= RST_WIDE_DIR;
		else if (wr_fire && wr_idx == IDX_WIDE_DIR && s_axi_wstrb[0])
			wide_dir_q <= {1'b1, wbyte[WIDE_W-1:0]};
	end

	always_ff @(posedge aclk)
	begin
		if (store_reset)
			narrow_data_q <= RST_NARROW_DATA;
		else if (wr_fire && wr_idx == IDX_NARROW_DATA && s_axi_wstrb[0])
			narrow_data_q <= wbyte;
	end

	always_ff @(posedge aclk)
	begin
		if (store_reset)
			wide_data_q <= RST_WIDE_DATA;
		else if (wr_fire && wr_idx == IDX_WIDE_DATA && s_axi_wstrb[0])
			wide_data_q <= {1'b1, wbyte[WIDE_W-1:0]};
	end

	always_ff @(posedge aclk)
	begin
		if (store_reset)
			narrow_pullup_q <= RST_NARROW_PULLUP;
		else if (wr_fire && wr_idx == IDX_NARROW_PULLUP && s_axi_wstrb[0])
			narrow_pullup_q <= wbyte;
	end

	// register read side
	assign rd_fire = arready_q && s_axi_arvalid;
	assign rd_idx = s_axi_araddr[17:2];

	always_comb
	begin
		rd_hit = (s_axi_araddr[1:0] == 2'h0);
		rd_byte = 8'h00;
		case (rd_idx)
			IDX_NARROW_DIR: rd_byte = READ_ALL_ONES;
			IDX_WIDE_DIR: rd_byte = READ_ALL_ONES;
			IDX_NARROW_DATA:
			begin
				rd_byte[7:NARROW_W] = narrow_data_q[7:NARROW_W];
				for (int i = 0; i < NARROW_W; i++)
					rd_byte[i] = n_dir_eff[i] ? narrow_data_q[i] : n_sync[i];
			end
			IDX_WIDE_DATA:
			begin
				rd_byte[WIDE_RSV_BIT] = 1'b1;
				for (int i = 0; i < WIDE_W; i++)
					rd_byte[i] = wide_dir_q[i] ? wide_data_q[i] : w_sync[i];
			end
			IDX_NARROW_PULLUP: rd_byte = narrow_pullup_q;
			default: rd_hit = 1'b0;
		endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			arready_q <= 1'b0;
		else
			arready_q <= !arready_q && s_axi_arvalid && !rvalid_q;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid_q <= 1'b0;
			rresp_q <= RESP_OKAY;
			rdata_q <= 32'h0000_0000;
		end
		else if (rd_fire)
		begin
			rvalid_q <= 1'b1;
			rresp_q <= rd_hit ? RESP_OKAY : RESP_DECERR;
			rdata_q <= rd_hit ? {24'h00_0000, rd_byte} : 32'h0000_0000;
		end
		else if (s_axi_rready)
			rvalid_q <= 1'b0;
	end

	// pin function selection
	assign wait_pin_fn = !(&wait_state_enables) || wait_mode_sel_high;

	always_comb
	begin
		n_out_d = narrow_data_q[NARROW_W-1:0];
		n_oe_d = n_dir_eff;
		n_pu_d = '0;
		if (romless)
			n_out_d = upper_addr;
		else if (mode_q == MODE_ROM_EXP)
			n_out_d = upper_addr;
		if (!romless)
			n_pu_d = narrow_pullup_q[NARROW_W-1:0] & ~n_dir_eff;
	end

	always_comb
	begin
		w_out_d = wide_data_q[WIDE_W-1:0];
		w_oe_d = wide_dir_q[WIDE_W-1:0];
		if (expanded)
		begin
			w_oe_d[PIN_AS:PIN_LWR-3] = '1;
			w_oe_d[PIN_LWR] = 1'b1;
			w_oe_d[PIN_HWR] = 1'b1;
			w_oe_d[PIN_RD] = 1'b1;
			w_out_d[PIN_AS] = addr_strobe_n;
			if (dram_area3 && dram_alt_assign)
			begin
				w_out_d[PIN_LWR] = dram_lower_column_strobe_n;
				w_out_d[PIN_HWR] = dram_upper_column_strobe_n;
				w_out_d[PIN_RD] = dram_write_enable_n;
			end
			else if (dram_area3)
			begin
				w_out_d[PIN_LWR] = dram_lower_write_n;
				w_out_d[PIN_HWR] = dram_upper_write_n;
				w_out_d[PIN_RD] = dram_column_strobe_n;
			end
			else
			begin
				w_out_d[PIN_LWR] = low_byte_write_strobe_n;
				w_out_d[PIN_HWR] = high_byte_write_strobe_n;
				w_out_d[PIN_RD] = read_strobe_n;
			end
			if (bus_release_enable)
			begin
				w_oe_d[PIN_BACK] = 1'b1;
				w_out_d[PIN_BACK] = bus_grant_ack_n;
				w_oe_d[PIN_BUS_REQUEST_IN] = 1'b0;
			end
			// wait function forces that direction bit clear, whatever software wrote
			if (wait_pin_fn)
				w_oe_d[PIN_WAIT] = 1'b0;
		end
	end

	// pins released in hardware standby, frozen in software standby
	always_ff @(posedge aclk)
	begin
		if (store_reset)
		begin
			n_out_q <= '0;
			n_oe_q <= '0;
			w_out_q <= '0;
			w_oe_q <= '0;
		end
		else if (!sw_standby)
		begin
			n_out_q <= n_out_d;
			n_oe_q <= n_oe_d;
			w_out_q <= w_out_d;
			w_oe_q <= w_oe_d;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (store_reset)
			n_pu_q <= '0;
		else
			n_pu_q <= n_pu_d;
	end

	// idle-high requests toward the bus controller when not in that function
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			bus_request_in_q <= 1'b1;
			wait_q <= 1'b1;
		end
		else
		begin
			bus_request_in_q <= (expanded && bus_release_enable) ? w_sync[PIN_BUS_REQUEST_IN] : 1'b1;
			wait_q <= (expanded && wait_pin_fn) ? w_sync[PIN_WAIT] : 1'b1;
		end
	end

	assign s_axi_awready = awready_q;
	assign s_axi_wready = wready_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rresp = rresp_q;
	assign s_axi_rdata = rdata_q;
	assign narrow_pin_out = n_out_q;
	assign narrow_pin_oe = n_oe_q;
	assign narrow_pullup_on = n_pu_q;
	assign wide_pin_out = w_out_q;
	assign wide_pin_oe = w_oe_q;
	assign bus_request_in_n = bus_request_in_q;
	assign wait_in_n = wait_q;
endmodule

// *** hdl/port_pkg.sv ***
// constants for the address-bus / bus-control pin ports
// assumes a 32-bit axi4-lite register bus and a 25 MHz system clock
package port_pkg;
	localparam int ADDR_W = 18;
	// register indices; byte address is four times the index
	localparam logic [15:0] IDX_NARROW_DIR = 16'hffc8;
	localparam logic [15:0] IDX_WIDE_DIR = 16'hffc9;
	localparam logic [15:0] IDX_NARROW_DATA = 16'hffca;
	localparam logic [15:0] IDX_WIDE_DATA = 16'hffcb;
	localparam logic [15:0] IDX_NARROW_PULLUP = 16'hffdb;
	localparam logic [7:0] RST_NARROW_DIR = 8'hf0;
	localparam logic [7:0] RST_WIDE_DIR = 8'h80;
	localparam logic [7:0] RST_NARROW_DATA = 8'hf0;
	localparam logic [7:0] RST_WIDE_DATA = 8'h80;
	localparam logic [7:0] RST_NARROW_PULLUP = 8'hf0;
	localparam logic [7:0] READ_ALL_ONES = 8'hff;
	localparam int WIDE_RSV_BIT = 7;
	localparam int NARROW_W = 4;
	localparam int WIDE_W = 7;
	// wide-port pin positions
	localparam int PIN_LWR = 6;
	localparam int PIN_HWR = 5;
	localparam int PIN_RD = 4;
	localparam int PIN_AS = 3;
	localparam int PIN_BACK = 2;
	localparam int PIN_BUS_REQUEST_IN = 1;
	localparam int PIN_WAIT = 0;
	// operating modes
	localparam logic [2:0] MODE_ROMLESS_LAST = 3'h4;
	localparam logic [2:0] MODE_ROM_EXP = 3'h5;
	localparam logic [2:0] MODE_SINGLE_FIRST = 3'h6;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;
	localparam int SYNC_STAGES = 3;
endpackage

// *** hdl/pin_sync_if.sv ***
// carries raw pin levels into the synchroniser and the filtered levels back
// assumes one clock domain on the filtered side
`timescale 1ns/1ps
interface pin_sync_if #(parameter int W = 1);
	logic [W-1:0] raw;
	logic [W-1:0] stable;
	modport sync (input raw, output stable);
	modport user (output raw, input stable);
endinterface

// *** hdl/pin_sync.sv ***
// three-stage pin synchroniser with agreement filter
// assumes raw levels are asynchronous to aclk
`timescale 1ns/1ps
module pin_sync
	import port_pkg::*;
#(
	parameter int W = 1,
	parameter logic [W-1:0] INIT = '1
)(
	input wire logic aclk, // system clock
	input wire logic aresetn, // synchronous reset, low active
	pin_sync_if.sync s // raw in, filtered out
);
	logic [W-1:0] ff1_q;
	logic [W-1:0] ff2_q;
	logic [W-1:0] ff3_q;
	logic [W-1:0] stable_q;

	// ff1 feeds only ff2; filter looks at stages two and three
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ff1_q <= INIT;
			ff2_q <= INIT;
			ff3_q <= INIT;
		end
		else
		begin
			ff1_q <= s.raw;
			ff2_q <= ff1_q;
			ff3_q <= ff2_q;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			stable_q <= INIT;
		else
		begin
			for (int i = 0; i < W; i++)
				if (ff2_q[i] == ff3_q[i])
					stable_q[i] <= ff3_q[i];
		end
	end

	assign s.stable = stable_q;
endmodule

// *** verif/pin_loads.sv ***
// pin loads: narrow-port pull-ups and outside drivers on both ports
// assumes the bench holds the outside drive values
`timescale 1ns/1ps
module pin_loads
(
	input wire logic [3:0] n_out, // narrow drive value
	input wire logic [3:0] n_oe, // narrow drive enable
	input wire logic [3:0] n_pu, // narrow pull-up on
	input wire logic [3:0] n_ext, // outside narrow level
	input wire logic [6:0] w_out, // wide drive value
	input wire logic [6:0] w_oe, // wide drive enable
	input wire logic [6:0] w_ext, // outside wide level
	output logic [3:0] n_lvl, // narrow pin level
	output logic [6:0] w_lvl // wide pin level
);
	// outside driver is weak: chip drive wins, pull-up lifts a floating pin
	assign n_lvl = (n_oe & n_out) | (~n_oe & (n_pu | n_ext));
	assign w_lvl = (w_oe & w_out) | (~w_oe & w_ext);
endmodule

// *** verif/port_checks_props.sv ***
// concurrent checks on the pin port block
// assumes it is bound to the top module and sees only its ports
`timescale 1ns/1ps
module port_checks
	import port_pkg::*;
(
	input wire logic aclk, // clock
	input wire logic aresetn, // reset
	input wire logic s_axi_awvalid, // bus
	input wire logic s_axi_awready, // bus
	input wire logic s_axi_wvalid, // bus
	input wire logic s_axi_wready, // bus
	input wire logic s_axi_bvalid, // bus
	input wire logic s_axi_arvalid, // bus
	input wire logic s_axi_arready, // bus
	input wire logic s_axi_rvalid, // bus
	input wire logic [2:0] mode_pins, // mode
	input wire logic hw_standby, // standby
	input wire logic sw_standby, // standby
	input wire logic [3:0] upper_addr, // address
	input wire logic addr_strobe_n, // strobe
	input wire logic read_strobe_n, // strobe
	input wire logic dram_area3, // dram
	input wire logic [7:0] wait_state_enables, // wait
	input wire logic wait_mode_sel_high, // wait
	input wire logic [3:0] narrow_pin_out, // pin
	input wire logic [3:0] narrow_pin_oe, // pin
	input wire logic [3:0] narrow_pullup_on, // pin
	input wire logic [6:0] wide_pin_out, // pin
	input wire logic [6:0] wide_pin_oe, // pin
	input wire logic bus_request_in_n, // filtered
	input wire logic wait_in_n // filtered
);
	logic [2:0] mode_q;
	logic run;
	// straps only count while reset is held
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			mode_q <= mode_pins;
	end
	assign run = !hw_standby && !sw_standby;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	chk_narrow_addr: assert property (mode_q <= 3'h4 && run |=>
		narrow_pin_oe == 4'hf && narrow_pin_out == $past(upper_addr)) else $error("narrow address");
	chk_pullup_off: assert property (mode_q <= 3'h4 |-> narrow_pullup_on == 4'h0)
		else $error("pull-up on");
	chk_mode5_addr: assert property (mode_q == MODE_ROM_EXP && run |=>
		(narrow_pin_out & narrow_pin_oe) == ($past(upper_addr) & narrow_pin_oe)) else $error("mode5");
	chk_bus_strobes: assert property (mode_q <= MODE_ROM_EXP && run && !dram_area3 |=>
		wide_pin_oe[6:3] == 4'hf && wide_pin_out[3] == $past(addr_strobe_n)
		&& wide_pin_out[4] == $past(read_strobe_n)) else $error("strobe pins");
	chk_wait_input: assert property (mode_q <= MODE_ROM_EXP && run &&
		(wait_state_enables != 8'hff || wait_mode_sel_high) |=> !wide_pin_oe[0]) else $error("wait");
	chk_single_idle: assert property (mode_q >= MODE_SINGLE_FIRST |->
		bus_request_in_n && wait_in_n) else $error("idle inputs");
	chk_hw_off: assert property (hw_standby |=> narrow_pin_oe == 4'h0 &&
		wide_pin_oe == 7'h00 && narrow_pullup_on == 4'h0) else $error("hw standby");
	chk_sw_hold: assert property (sw_standby && !hw_standby |=> $stable(narrow_pin_oe)
		&& $stable(wide_pin_oe) && $stable(wide_pin_out)) else $error("sw standby");
	chk_write_resp: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready |=> s_axi_bvalid) else $error("write resp");
	chk_read_resp: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read resp");
	chk_ready_pulse: assert property (s_axi_awready |-> s_axi_wready ##1 !s_axi_awready)
		else $error("ready pulse");
endmodule

bind addr_bus_ctrl_gpio_ports port_checks port_checks_inst (.*);

// *** verif/test_addr_bus_ctrl_gpio_ports.sv ***
// self-checking bench for the narrow and wide pin ports
// assumes port_pkg, the pin-load model and the bound checker compile first
`timescale 1ns/1ps
module test_addr_bus_ctrl_gpio_ports
	import port_pkg::*;
;
	logic aclk = 0, aresetn = 0, hw_standby = 0, sw_standby = 0;
	logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [31:0] s_axi_wdata = '0, s_axi_rdata, seed = 32'h0000_0011;
	logic [3:0] s_axi_wstrb = 4'hf, upper_addr = '0, n_ext = '0;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [2:0] mode_pins = 3'h1;
	logic low_byte_write_strobe_n = 1, high_byte_write_strobe_n = 1, read_strobe_n = 1;
	logic addr_strobe_n = 1, bus_grant_ack_n = 1, bus_release_enable = 0;
	logic wait_mode_sel_high = 0, dram_area3 = 0, dram_alt_assign = 0;
	logic dram_lower_write_n = 1, dram_upper_write_n = 1, dram_column_strobe_n = 1;
	logic dram_lower_column_strobe_n = 1, dram_upper_column_strobe_n = 1;
	logic dram_write_enable_n = 1, bus_request_in_n, wait_in_n;
	logic [7:0] wait_state_enables = 8'hff;
	logic [3:0] narrow_pin_in, narrow_pin_out, narrow_pin_oe, narrow_pullup_on;
	logic [6:0] wide_pin_in, wide_pin_out, wide_pin_oe, w_ext = '0;
	int n_errors = 0, n_checks = 0;
	always #20 aclk = ~aclk;
	addr_bus_ctrl_gpio_ports addr_bus_ctrl_gpio_ports_inst (.*);
	pin_loads pin_loads_inst (.n_out(narrow_pin_out), .n_oe(narrow_pin_oe),
		.n_pu(narrow_pullup_on), .n_ext(n_ext), .w_out(wide_pin_out), .w_oe(wide_pin_oe),
		.w_ext(w_ext), .n_lvl(narrow_pin_in), .w_lvl(wide_pin_in));
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	// modes 1-4 read stored bits; inputs see pull-up or outside level
	function automatic logic [7:0] nrd(input int m, input logic [7:0] d, v, p);
		if (m <= 4)
			return v;
		return {v[7:4], (v[3:0] & d[3:0]) | ((p[3:0] | n_ext) & ~d[3:0])};
	endfunction
	// expanded modes: strobes on 6-3, release and wait functions on 2-0
	function automatic logic [13:0] wexp(input int m, input logic [7:0] wd, wv);
		logic [6:0] oe, o;
		oe = wd[6:0];
		o = wv[6:0];
		if (m <= 5)
		begin
			oe[6:3] = 4'hf;
			o[6:3] = {low_byte_write_strobe_n, high_byte_write_strobe_n, read_strobe_n,
				addr_strobe_n};
			if (dram_area3 && dram_alt_assign)
				o[6:4] = {dram_lower_column_strobe_n, dram_upper_column_strobe_n, dram_write_enable_n};
			else if (dram_area3)
				o[6:4] = {dram_lower_write_n, dram_upper_write_n, dram_column_strobe_n};
			if (bus_release_enable)
			begin
				oe[2:1] = 2'b10;
				o[2] = bus_grant_ack_n;
			end
			if (wait_state_enables != 8'hff || wait_mode_sel_high)
				oe[0] = 1'b0;
		end
		return {oe, o & oe};
	endfunction
	// request and wait follow the released pin only while in that function
	function automatic logic [1:0] iexp(input int m);
		logic wf;
		wf = (wait_state_enables != 8'hff) || wait_mode_sel_high;
		return {!(m <= 5 && bus_release_enable) || w_ext[PIN_BUS_REQUEST_IN],
			!(m <= 5 && wf) || w_ext[PIN_WAIT]};
	endfunction
	task summarize();
		$display("errors %0d checks %0d", n_errors, n_checks);
		if (n_errors == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// bounded wait on one handshake signal
	task await(input int w);
		logic [3:0] s;
		for (int k = 0; k < 50; k++)
		begin
			@(posedge aclk);
			s = {s_axi_rvalid, s_axi_arready, s_axi_bvalid, s_axi_awready};
			if (s[w] === 1'b1)
				return;
		end
		n_errors++;
		$display("mismatch at %0t: no answer", $time);
		summarize();
	endtask
	task wr(input logic [15:0] i, input logic [7:0] d, output logic [1:0] r);
		s_axi_awaddr <= {i, 2'b00};
		s_axi_wdata <= {24'h00_0000, d};
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		await(0);
		s_axi_awvalid <= 0;
		s_axi_wvalid <= 0;
		await(1);
		r = s_axi_bresp;
		s_axi_bready <= 0;
		// one edge apart, so a following call never re-raises ready in this step
		@(posedge aclk);
	endtask
	task rd(input logic [15:0] i, output logic [31:0] d, output logic [1:0] r);
		s_axi_araddr <= {i, 2'b00};
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		await(2);
		s_axi_arvalid <= 0;
		await(3);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 0;
		@(posedge aclk);
	endtask
	task verify(input int m, input logic [7:0] d, v, p, wd, wv);
		logic [31:0] got;
		logic [1:0] r;
		logic [7:0] mk;
		logic [3:0] no;
		mk = (m >= 6) ? 8'hff : {1'b1, wd[6:0]};
		no = (m >= 5) ? d[3:0] : 4'hf;
		rd(IDX_NARROW_DIR, got, r);
		chk(got, 32'h0000_00ff);
		rd(IDX_WIDE_DIR, got, r);
		chk(got, 32'h0000_00ff);
		rd(IDX_NARROW_DATA, got, r);
		chk(got, {24'h00_0000, nrd(m, d, v, p)});
		chk(r, RESP_OKAY);
		rd(IDX_WIDE_DATA, got, r);
		chk(got & mk, {24'h00_0000, 1'b1, (wv[6:0] & wd[6:0]) | (w_ext & ~wd[6:0])} & mk);
		chk(narrow_pullup_on, (m >= 5) ? p[3:0] & ~d[3:0] : 4'h0);
		chk(narrow_pin_oe, no);
		chk(narrow_pin_out & no, ((m >= 6) ? v[3:0] : upper_addr) & no);
		if (m >= 6)
			chk({wide_pin_oe, wide_pin_out & wd[6:0]}, {wd[6:0], wv[6:0] & wd[6:0]});
		chk({wide_pin_oe, wide_pin_out & wide_pin_oe}, wexp(m, wd, wv));
		chk({bus_request_in_n, wait_in_n}, iexp(m));
	endtask
	initial
	begin
		logic [7:0] d, v, p, wd, wv;
		logic [31:0] c, got;
		logic [1:0] r;
		for (int m = 1; m < 8; m++)
		begin
			c = xs();
			{d, v, p, wd} = c;
			c = xs();
			wv = c[7:0];
			if (m <= 5)
				wd[0] = 1'b0;
			aresetn <= 0;
			mode_pins <= m[2:0];
			{n_ext, w_ext, upper_addr} <= c[22:8];
			c = xs();
			{low_byte_write_strobe_n, high_byte_write_strobe_n, read_strobe_n, addr_strobe_n,
				bus_grant_ack_n, bus_release_enable, wait_mode_sel_high, dram_area3,
				dram_alt_assign, dram_lower_write_n, dram_upper_write_n, dram_column_strobe_n,
				dram_lower_column_strobe_n, dram_upper_column_strobe_n, dram_write_enable_n,
				wait_state_enables} <= c[22:0];
			repeat (6) @(posedge aclk);
			aresetn <= 1;
			@(posedge aclk);
			verify(m, RST_NARROW_DIR, RST_NARROW_DATA, RST_NARROW_PULLUP, RST_WIDE_DIR,
				RST_WIDE_DATA);
			wr(IDX_NARROW_DIR, d, r);
			wr(IDX_WIDE_DIR, wd, r);
			wr(IDX_NARROW_PULLUP, p, r);
			wr(IDX_NARROW_DATA, v, r);
			wr(IDX_WIDE_DATA, wv, r);
			chk(r, RESP_OKAY);
			repeat (6) @(posedge aclk);
			verify(m, d, v, p, wd, wv);
			wr(16'hffcc, 8'h5a, r);
			chk(r, RESP_DECERR);
			rd(16'hffcc, got, r);
			chk(got, 32'h0000_0000);
			chk(r, RESP_DECERR);
			// outputs must freeze while the address moves underneath
			sw_standby <= 1;
			upper_addr <= ~upper_addr;
			repeat (4) @(posedge aclk);
			sw_standby <= 0;
			repeat (6) @(posedge aclk);
			verify(m, d, v, p, wd, wv);
			hw_standby <= 1;
			repeat (3) @(posedge aclk);
			hw_standby <= 0;
			repeat (6) @(posedge aclk);
			verify(m, RST_NARROW_DIR, RST_NARROW_DATA, RST_NARROW_PULLUP, RST_WIDE_DIR,
				RST_WIDE_DATA);
		end
		summarize();
	end
endmodule
